// ===== common/iepe_cfg_map.svh
`ifndef IEPE_CFG_MAP_SVH
`define IEPE_CFG_MAP_SVH
`define IEPE_NUM_CH 4
`define IEPE_ALL_CH 4'hF
`define IEPE_MSK_LEVEL 0
`define IEPE_MSK_EXCON 1
`define IEPE_MSK_OPENTH 2
`define IEPE_MSK_SHORTTH 3
`define IEPE_MSK_ALARM 4
`define IEPE_MSK_COUPLE 5
`define IEPE_MSK_TEST 6
`define IEPE_MSK_FILT 7
`define IEPE_MSK_PRIM 8
`define IEPE_MSK_MONEN 9
`define IEPE_MSK_RATIO 10
`define IEPE_MSK_DEFAULT 11
`define IEPE_DEF_LEVEL 8'h00
`define IEPE_DEF_EXCON 1'h0
`define IEPE_DEF_OPENTH 12'h000
`define IEPE_DEF_SHORTTH 12'h000
`define IEPE_SHORT_TH_STANDARD 12'h0C0
`define IEPE_DEF_ALARM 16'h0000
`define IEPE_DC_COUPLING_BIT 4'h1
`define IEPE_DEF_COUPLE 4'h1
`define IEPE_DEF_TEST 1'h0
`define IEPE_DEF_FILT 1'h0
`define IEPE_DEF_PRIM 1'h0
`define IEPE_DEF_MONEN 1'h0
`define IEPE_DEF_RATIO 15'h0000
`endif

// ===== common/iepe_pkg.sv
package iepe_pkg;
  typedef struct packed {
    logic [7:0] level;
    logic excOn;
    logic [11:0] openTh;
    logic [11:0] shortTh;
    logic [15:0] alarm;
    logic [3:0] couple;
    logic test;
    logic filt;
    logic prim;
    logic monEn;
    logic [14:0] ratio;
  } iepe_chcfg_t;
  typedef enum logic [0:0] {
    IEPE_IDLE = 1'b0,
    IEPE_APPLY = 1'b1
  } iepe_wstate_t;
endpackage : iepe_pkg

// ===== src/iepe_alarm_cmp.sv
`timescale 1ns/1ps
`include "iepe_cfg_map.svh"
module iepe_alarm_cmp
  import iepe_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic monEn,
  input wire logic [11:0] level,
  input wire logic [11:0] openTh,
  input wire logic [11:0] shortTh,
  output logic openAlarm,
  output logic shortAlarm
);
  logic open_r, open_nxt, short_r, short_nxt;
  always_comb begin
    // comparison only meaningful while the monitor converter runs
    open_nxt = monEn && (level > openTh); // see (R7) see (R19)
    short_nxt = monEn && (shortTh != 12'h000) && (level < shortTh); // see (R8) see (R19)
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      open_r <= 1'b0;
      short_r <= 1'b0;
    end else begin
      open_r <= open_nxt;
      short_r <= short_nxt;
    end
  end
  assign openAlarm = open_r;
  assign shortAlarm = short_r;
endmodule : iepe_alarm_cmp

// ===== src/iepe_channel_config.sv
`timescale 1ns/1ps
`include "iepe_cfg_map.svh"
// Operation
// (R1) unmasked fields keep their previous value
// (R2) channel-select bits choose written channels
// (R3) mask bit 11 restores channel defaults
// (R4) mask bits 0-10 enable individual fields
// (R5) level code 0-255 sets drive current
// (R6) excitation on/off switches drive current
// (R7) 12-bit open threshold detects open sensor
// (R8) 12-bit short threshold, zero disables
// (R9) host keeps thresholds within 0x30-0xE0
// (R10) coupling one-hot: DC, 0.1, 1, 10 Hz
// (R11) test mode on/off, default off
// (R12) monitor converter enable on/off
// (R13) alarm control updated only by bit 4; the code also loads its default on a restore (bit 11)
// (R14) host restores defaults on all channels first
// (R15) analog filter enable on/off
// (R16) primary flow stop or allow
// (R17) monitor ratio 0-32767, zero stops transfer
// (R18) excitation off plus test grounds input
// (R19) flag open above, short below threshold
// (R20) whole write applied in one cycle
module iepe_channel_config
  import iepe_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cfgWrite,
  input wire logic [3:0] chanSelect,
  input wire logic [11:0] fieldMask,
  input wire logic [7:0] wrLevel,
  input wire logic wrExcOn,
  input wire logic [11:0] wrOpenTh,
  input wire logic [11:0] wrShortTh,
  input wire logic [15:0] wrAlarm,
  input wire logic [3:0] wrCouple,
  input wire logic wrTest,
  input wire logic wrFilt,
  input wire logic wrPrim,
  input wire logic wrMonEn,
  input wire logic [14:0] wrRatio,
  input wire logic [47:0] monLevel,
  output logic [31:0] driveLevel,
  output logic [3:0] driveOn,
  output logic [47:0] openThOut,
  output logic [47:0] shortThOut,
  output logic [63:0] alarmCtrl,
  output logic [15:0] couplingSel,
  output logic [3:0] testMode,
  output logic [3:0] inputGround,
  output logic [3:0] filterOn,
  output logic [3:0] primaryFlow,
  output logic [3:0] monitorOn,
  output logic [59:0] monitorRatio,
  output logic [3:0] monitorXfer,
  output logic [3:0] openAlarm,
  output logic [3:0] shortAlarm
);
  localparam iepe_chcfg_t DEF_CFG = '{
    level: `IEPE_DEF_LEVEL, excOn: `IEPE_DEF_EXCON, openTh: `IEPE_DEF_OPENTH,
    shortTh: `IEPE_DEF_SHORTTH, alarm: `IEPE_DEF_ALARM, couple: `IEPE_DEF_COUPLE,
    test: `IEPE_DEF_TEST, filt: `IEPE_DEF_FILT, prim: `IEPE_DEF_PRIM,
    monEn: `IEPE_DEF_MONEN, ratio: `IEPE_DEF_RATIO};

  genvar ch;
  generate
    for (ch = 0; ch < `IEPE_NUM_CH; ch++) begin : gCh
      iepe_chcfg_t cfg_r, cfg_nxt;
      logic ground_r, ground_nxt, xfer_r, xfer_nxt;
      always_comb begin
        cfg_nxt = cfg_r; // see (R1)
        // one combinational update per write, no partial channel state
        if (cfgWrite && chanSelect[ch]) begin // see (R2) see (R20)
          if (fieldMask[`IEPE_MSK_DEFAULT]) begin
            // restore wins over every other mask bit in the same write
            cfg_nxt = DEF_CFG; // see (R3)
          end else begin
            if (fieldMask[`IEPE_MSK_LEVEL]) cfg_nxt.level = wrLevel; // see (R4) see (R5)
            if (fieldMask[`IEPE_MSK_EXCON]) cfg_nxt.excOn = wrExcOn; // see (R6)
            if (fieldMask[`IEPE_MSK_OPENTH]) cfg_nxt.openTh = wrOpenTh; // see (R7)
            if (fieldMask[`IEPE_MSK_SHORTTH]) cfg_nxt.shortTh = wrShortTh; // see (R8)
            if (fieldMask[`IEPE_MSK_ALARM]) cfg_nxt.alarm = wrAlarm; // see (R13)
            if (fieldMask[`IEPE_MSK_COUPLE]) cfg_nxt.couple = wrCouple; // see (R10)
            if (fieldMask[`IEPE_MSK_TEST]) cfg_nxt.test = wrTest; // see (R11)
            if (fieldMask[`IEPE_MSK_FILT]) cfg_nxt.filt = wrFilt; // see (R15)
            if (fieldMask[`IEPE_MSK_PRIM]) cfg_nxt.prim = wrPrim; // see (R16)
            if (fieldMask[`IEPE_MSK_MONEN]) cfg_nxt.monEn = wrMonEn; // see (R12)
            if (fieldMask[`IEPE_MSK_RATIO]) cfg_nxt.ratio = wrRatio; // see (R17)
          end
        end
        ground_nxt = !cfg_nxt.excOn && cfg_nxt.test; // see (R18)
        xfer_nxt = cfg_nxt.monEn && (cfg_nxt.ratio != 15'h0000); // see (R17)
      end
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          cfg_r <= DEF_CFG;
          ground_r <= 1'b0;
          xfer_r <= 1'b0;
        end else begin
          cfg_r <= cfg_nxt;
          ground_r <= ground_nxt;
          xfer_r <= xfer_nxt;
        end
      end
      assign driveLevel[ch*8 +: 8] = cfg_r.level;
      // drive is held off while the input is grounded for adjustment
      assign driveOn[ch] = cfg_r.excOn; // see (R6)
      assign openThOut[ch*12 +: 12] = cfg_r.openTh;
      assign shortThOut[ch*12 +: 12] = cfg_r.shortTh;
      assign alarmCtrl[ch*16 +: 16] = cfg_r.alarm;
      assign couplingSel[ch*4 +: 4] = cfg_r.couple; // see (R10)
      assign testMode[ch] = cfg_r.test;
      assign inputGround[ch] = ground_r;
      assign filterOn[ch] = cfg_r.filt;
      assign primaryFlow[ch] = cfg_r.prim;
      assign monitorOn[ch] = cfg_r.monEn;
      assign monitorRatio[ch*15 +: 15] = cfg_r.ratio;
      assign monitorXfer[ch] = xfer_r;
      // alarms keep working with ratio zero; only transfer stops
      iepe_alarm_cmp uCmp (
        .core_clk(core_clk),
        .resetn(resetn),
        .monEn(cfg_r.monEn),
        .level(monLevel[ch*12 +: 12]),
        .openTh(cfg_r.openTh),
        .shortTh(cfg_r.shortTh),
        .openAlarm(openAlarm[ch]),
        .shortAlarm(shortAlarm[ch])
      ); // see (R19)
    end
  endgenerate
endmodule : iepe_channel_config

// ===== tb/iepe_sensor_model.sv
`timescale 1ns/1ps
module iepe_sensor_model (
  input wire logic [3:0] driveOn,
  input wire logic [7:0] fault,
  output logic [47:0] monLevel
);
  // fault per channel: 0 healthy, 1 open, 2 shorted; no drive reads as ground
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!driveOn[i] || fault[2*i+:2] == 2'h2) monLevel[12*i+:12] = 12'h000;
      else if (fault[2*i+:2] == 2'h1) monLevel[12*i+:12] = 12'hFFF;
      else monLevel[12*i+:12] = 12'h0DA;
    end
  end
endmodule : iepe_sensor_model

// ===== tb/iepe_channel_config_checker.sv
`timescale 1ns/1ps
module iepe_channel_config_checker (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cfgWrite,
  input wire logic [3:0] chanSelect,
  input wire logic [11:0] fieldMask,
  input wire logic [7:0] wrLevel,
  input wire logic wrExcOn,
  input wire logic [47:0] monLevel,
  input wire logic [31:0] driveLevel,
  input wire logic [3:0] driveOn,
  input wire logic [47:0] openThOut,
  input wire logic [47:0] shortThOut,
  input wire logic [15:0] couplingSel,
  input wire logic [3:0] testMode,
  input wire logic [3:0] inputGround,
  input wire logic [3:0] monitorOn,
  input wire logic [59:0] monitorRatio,
  input wire logic [3:0] monitorXfer,
  input wire logic [3:0] shortAlarm
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_MASK_KEEP:
    assert property (cfgWrite && !fieldMask[11] && !fieldMask[0] |=> $stable(driveLevel))
    else $error("level moved without its mask bit");
  AST_CHAN_KEEP:
    assert property (cfgWrite && !chanSelect[0] |=> $stable(openThOut[11:0]))
    else $error("unselected channel changed");
  AST_RESTORE:
    assert property (cfgWrite && fieldMask[11] && chanSelect[0] |=> couplingSel[3:0] == 4'h1
      && shortThOut[11:0] == 12'h000 && !driveOn[0]) else $error("restore left non-default");
  AST_LEVEL:
    assert property (cfgWrite && fieldMask == 12'h001 && chanSelect[0] |=>
      driveLevel[7:0] == $past(wrLevel)) else $error("level not written");
  AST_EXC:
    assert property (cfgWrite && fieldMask == 12'h002 && chanSelect[3] |=>
      driveOn[3] == $past(wrExcOn)) else $error("drive on not written");
  AST_GROUND:
    assert property (inputGround == (~driveOn & testMode)) else $error("grounding wrong");
  AST_XFER:
    assert property (monitorXfer[1] == (monitorOn[1] && monitorRatio[29:15] != 15'h0000))
    else $error("monitor transfer wrong");
  AST_SHORT:
    assert property (1'b1 |=> shortAlarm[2] == $past(monitorOn[2] && shortThOut[35:24] != 12'h000
      && monLevel[35:24] < shortThOut[35:24])) else $error("short alarm wrong");
  cover property (cfgWrite && fieldMask[11]);
  cover property (shortAlarm[2]);
  cover property (inputGround[0]);
endmodule : iepe_channel_config_checker
bind iepe_channel_config iepe_channel_config_checker u_chk (.*);

// ===== tb/test_iepe_channel_config.sv
`timescale 1ns/1ps
module test_iepe_channel_config;
  logic core_clk = 1'b0, resetn = 1'b0, cfgWrite = 1'b0, wrExcOn = 1'b0, wrTest = 1'b0;
  logic wrFilt = 1'b0, wrPrim = 1'b0, wrMonEn = 1'b0;
  logic [3:0] chanSelect = 4'h0, wrCouple = 4'h0;
  logic [7:0] wrLevel = 8'h00, fault = 8'h00;
  logic [11:0] fieldMask = 12'h000, wrOpenTh = 12'h000, wrShortTh = 12'h000;
  logic [15:0] wrAlarm = 16'h0000, couplingSel;
  logic [14:0] wrRatio = 15'h0000;
  logic [47:0] monLevel, openThOut, shortThOut;
  logic [31:0] driveLevel;
  logic [3:0] driveOn, testMode, inputGround, filterOn, primaryFlow, monitorOn;
  logic [3:0] monitorXfer, openAlarm, shortAlarm;
  logic [63:0] alarmCtrl;
  logic [59:0] monitorRatio;
  int failCount = 0, checks = 0;
  iepe_channel_config u_iepe_channel_config (.*);
  iepe_sensor_model u_iepe_sensor_model (.*);
  always #50 core_clk = ~core_clk;
  // every field is fed from one byte so expectations stay short
  task wr(input logic [3:0] c, input logic [11:0] m, input logic [7:0] v);
    @(posedge core_clk);
    {cfgWrite, chanSelect, fieldMask} <= {1'b1, c, m};
    {wrLevel, wrOpenTh, wrShortTh, wrAlarm} <= {v, 4'h0, v, 4'h0, v, 8'h00, v};
    {wrRatio, wrExcOn, wrTest, wrFilt, wrPrim, wrMonEn} <= {7'h00, v, v[0], v[1], v[2], v[3], v[4]};
    wrCouple <= v[3:0];
    @(posedge core_clk);
    cfgWrite <= 1'b0;
    #1;
  endtask : wr
  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task testDone();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : testDone
  initial begin
    repeat (3000) @(posedge core_clk);
    failCount++;
    testDone();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    wr(4'hF, 12'h800, 8'hFF);
    chk("restore", {couplingSel, driveLevel}, 48'h1111_00000000);
    wr(4'h6, 12'h001, 8'hFF);
    chk("level", {driveOn, driveLevel}, 36'h0_00FFFF00);
    for (int i = 0; i < 11; i++) wr(4'hF, 12'h001 << i, 8'hD5);
    chk("flags", {driveOn, testMode, filterOn, primaryFlow, monitorOn, couplingSel},
      36'hF0F0F5555);
    chk("drive", driveLevel, 32'hD5D5D5D5);
    chk("open", openThOut, 48'h0D50D50D50D5);
    chk("short", shortThOut, 48'h0D50D50D50D5);
    chk("alarmctl", alarmCtrl, 64'h00D500D500D500D5);
    chk("ratio", {monitorXfer, monitorRatio}, {4'hF, {4{15'h00D5}}});
    wr(4'h1, 12'h042, 8'h02);
    chk("ground", {inputGround, testMode, driveOn}, 12'h11E);
    wr(4'hF, 12'h004, 8'hE0);
    @(posedge core_clk);
    fault <= 8'h90;
    repeat (2) @(posedge core_clk);
    #1;
    // ch2 open reads full scale, ch0 undriven and ch3 shorted read ground
    chk("alarms", {openAlarm, shortAlarm}, 8'h49);
    wr(4'hF, 12'h008, 8'h00);
    repeat (2) @(posedge core_clk);
    #1;
    chk("shortoff", shortAlarm, 4'h0);
    wr(4'h8, 12'hFFF, 8'hFF);
    chk("partial", {couplingSel, driveLevel}, 48'h1555_00D5D5D5);
    wr(4'h2, 12'h400, 8'h00);
    chk("xfer", monitorXfer, 4'h5);
    testDone();
  end
endmodule : test_iepe_channel_config
